// ### uft_pkg.sv
package uft_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_CTRL_C = 8'h08;
  localparam logic [7:0] ADDR_BAUD_LO = 8'h0C;
  localparam logic [7:0] ADDR_BAUD_HI = 8'h10;
  localparam logic [7:0] ADDR_DATA = 8'h14;
  // ==========================================
  // Field positions
  localparam int A_RX_DONE = 7;
  localparam int A_TX_DONE = 6;
  localparam int A_BUF_EMPTY = 5;
  localparam int A_FRAME_ERR = 4;
  localparam int A_DOUBLE = 1;
  localparam int B_RX_EN = 4;
  localparam int B_TX_EN = 3;
  localparam int B_SIZE_HI = 2;
  localparam int B_RX_NINTH = 1;
  localparam int B_TX_NINTH = 0;
  localparam int C_XCK_MASTER = 7;
  localparam int C_SYNC = 6;
  localparam int C_PAR_HI = 5;
  localparam int C_PAR_LO = 4;
  localparam int C_STOP = 3;
  localparam int C_SIZE_HI = 2;
  localparam int C_SIZE_LO = 1;
  localparam int C_POL = 0;
  // ==========================================
  // Reset values and encodings
  localparam logic [2:0] RST_SIZE = 3'h3;
  localparam logic [11:0] RST_BAUD = 12'h000;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [3:0] BITS_MIN = 4'h5;
  localparam logic [3:0] BITS_RSVD = 4'h8;
  localparam logic [3:0] BITS_MAX = 4'h9;
  // Oversample ratio minus one, and mid-bit point
  localparam logic [3:0] DIV_NORMAL = 4'hF;
  localparam logic [3:0] DIV_DOUBLE = 4'h7;
  localparam logic [3:0] MID_NORMAL = 4'h7;
  localparam logic [3:0] MID_DOUBLE = 4'h3;

  typedef struct packed {
    logic sync;
    logic xck_master;
    logic pol;
    logic [1:0] parity;
    logic stop2;
    logic [2:0] size;
  } uft_fmt_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } uft_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } uft_apb_rsp_t;

  typedef enum logic {RX_IDLE = 1'b0, RX_BUSY = 1'b1} uft_rx_state_t;

  function automatic logic [3:0] data_bits(input logic [2:0] code);
    data_bits = (code == SIZE_NINE) ? BITS_MAX :
        (code[2] ? BITS_RSVD : BITS_MIN + {2'b00, code[1:0]});
  endfunction
endpackage

// ### uft_baud_gen.sv
`timescale 1ns/1ps
module uft_baud_gen (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Divisor
  input wire logic [11:0] divisor,
  input wire logic reload,
  // Rate pulse
  output logic tick
);
  import uft_pkg::*;
  logic [11:0] cnt;
  wire at_zero = (cnt == 12'h000);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= RST_BAUD;
      tick <= 1'b0;
    end else begin
      cnt <= (reload | at_zero) ? divisor : cnt - 12'h001; // R23
      tick <= at_zero & ~reload; // R23
    end
  end

  AST_BAUD_RELOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reload |=> cnt == $past(divisor)) // R23
    else $error("divisor not reloaded on write");
  AST_BAUD_TICK: assert property (@(posedge clk_sys) disable iff (!rst_n)
      at_zero && !reload |=> tick) // R23
    else $error("rate pulse missing at zero");
  AST_BAUD_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !at_zero || reload |=> !tick) // R23
    else $error("rate pulse away from zero");
endmodule

// ### uft_tx_shift.sv
`timescale 1ns/1ps
module uft_tx_shift (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Timing and format
  input wire logic bit_tick,
  input wire uft_pkg::uft_fmt_t fmt,
  // Buffer side
  input wire logic load_req,
  input wire logic [8:0] load_data,
  output logic load_ack,
  output logic frame_done,
  // Line side
  output logic txd,
  output logic busy
);
  import uft_pkg::*;
  logic [12:0] sr;
  logic [3:0] left;
  logic [11:0] dmask;
  logic [12:0] frame;
  wire [3:0] nbits = data_bits(fmt.size);
  wire par_on = fmt.parity[1];
  wire par_bit = (^dmask) ^ fmt.parity[0]; // R11
  wire [3:0] len = 4'h2 + nbits + {3'b000, par_on} + {3'b000, fmt.stop2}; // R1 R9
  wire last = busy & (left == 4'h1);

  // Unused upper data bits are dropped
  genvar i;
  generate
    for (i = 0; i < 12; i++) begin : g_mask
      if (i < 9) begin : g_d
        assign dmask[i] = load_data[i] & (i < nbits); // R20 R7 R27
      end else begin : g_z
        assign dmask[i] = 1'b0;
      end
    end
    for (i = 0; i < 13; i++) begin : g_frame
      if (i == 0) begin : g_start
        assign frame[i] = 1'b0; // R29
      end else begin : g_body
        assign frame[i] = (i <= nbits) ? dmask[i-1] : // R2
            ((par_on && i == nbits + 1) ? par_bit : 1'b1); // R3 R8 R28 R29
      end
    end
  endgenerate

  assign load_ack = bit_tick & load_req & (~busy | last); // R18
  assign frame_done = bit_tick & last & ~load_req;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sr <= 13'h1FFF;
      left <= 4'h0;
      busy <= 1'b0;
      txd <= 1'b1;
    end else if (load_ack) begin
      sr <= frame;
      left <= len;
      busy <= 1'b1;
      txd <= 1'b0;
    end else if (bit_tick & busy) begin
      sr <= {1'b1, sr[12:1]};
      left <= left - 4'h1;
      busy <= ~last;
      txd <= last ? 1'b1 : sr[1]; // R4
    end
  end

  AST_START_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
      load_ack |=> !txd && busy && left == $past(len)) // R29
    else $error("start bit not driven low");
  AST_LSB_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
      load_ack && fmt == $past(fmt) |=> sr[1] == $past(load_data[0])) // R2
    else $error("first data bit is not the least significant");
  AST_IDLE_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !busy |-> txd) // R4
    else $error("line not idle high");
  AST_BACK_TO_BACK: assert property (@(posedge clk_sys) disable iff (!rst_n)
      bit_tick && last && load_req |-> load_ack ##1 (busy && !txd)) // R18
    else $error("next frame did not follow the last stop bit");
endmodule

// ### uft_top.sv
// Functional notes
// [R1] Frame: one start, 5-9 data, optional parity, one or two stops.
// [R2] Data bits go out least significant first.
// [R3] Parity sits after last data bit, before first stop.
// [R4] Next frame may follow directly, otherwise line idles high.
// [R5] Receiver and transmitter share one frame format setting.
// [R6] Host keeps format fixed while a transfer runs.
// [R7] Size code selects data bit count; code 7 is nine bits.
// [R8] Parity mode selects presence and even or odd parity.
// [R9] Stop select gives one or two stops; receiver ignores second.
// [R10] Frame error only when the first stop bit samples zero.
// [R11] Parity is xor of data bits, inverted for odd.
// [R12] Host sets rate and format before enabling.
// [R13] Host clears done flag before each data write it relies on.
// [R14] Host checks idle and empty receive buffer before reconfiguring.
// [R15] Transmit enable hands the serial output pin to the transmitter.
// [R16] Synchronous mode uses the transfer clock pin as bit clock.
// [R17] Writing the data buffer loads it and starts sending.
// [R18] Buffer moves to shifter when idle or right after last stop.
// [R19] Shifter sends one frame at divisor, double speed or external rate.
// [R20] Unused upper data bits are ignored for short characters.
// [R21] Host writes only when the buffer empty flag is set.
// [R22] Host writes ninth bit before the low byte.
// [R23] Divisor down-counter reloads at zero or low byte write, pulses.
// [R24] Transmit divides rate by 16, 8 double speed, 2 sync master.
// [R25] Sync polarity 0 changes data on rising edge, 1 on falling.
// [R26] Buffer empty flag set while empty, cleared while data waits.
// [R27] Size codes 0-3 give 5-8 bits; 4-6 reserved.
// [R28] Parity codes: 00 none, 10 even, 11 odd, 01 reserved.
// [R29] Start bit low one bit time, each stop high one bit time.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module uft_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus
  input wire uft_pkg::uft_apb_req_t apb_req,
  output uft_pkg::uft_apb_rsp_t apb_rsp,
  // Serial output pin and general port logic
  input wire logic port_txd,
  input wire logic port_txd_oe,
  output logic txd_o,
  output logic txd_oe,
  // Serial input
  input wire logic rxd,
  // Transfer clock pin
  input wire logic xck_i,
  output logic xck_o,
  output logic xck_oe
);
  import uft_pkg::*;

  // ==========================================
  // Control state
  logic dbl;
  logic tx_en;
  logic rx_en;
  logic tx9;
  uft_fmt_t fmt;
  logic [11:0] baud;
  logic [8:0] buf_data;
  logic buf_full;
  logic tx_done;
  logic rx_done;
  logic [8:0] rx_data;
  logic fe;

  // ==========================================
  // Bus decode
  wire acc = apb_req.psel & apb_req.penable;
  wire [7:0] wd = apb_req.pwdata[7:0];
  wire hit_a = (apb_req.paddr == ADDR_CTRL_A);
  wire hit_b = (apb_req.paddr == ADDR_CTRL_B);
  wire hit_c = (apb_req.paddr == ADDR_CTRL_C);
  wire hit_lo = (apb_req.paddr == ADDR_BAUD_LO);
  wire hit_hi = (apb_req.paddr == ADDR_BAUD_HI);
  wire hit_d = (apb_req.paddr == ADDR_DATA);
  wire mapped = hit_a | hit_b | hit_c | hit_lo | hit_hi | hit_d;
  wire wr_fire = acc & apb_req.pwrite & apb_rsp.pready;
  wire rd_fire = acc & ~apb_req.pwrite & apb_rsp.pready;
  wire data_wr = wr_fire & hit_d;
  wire lo_wr = wr_fire & hit_lo;
  wire data_rd = rd_fire & hit_d;

  // ==========================================
  // Read mux
  wire [7:0] rd_a = {rx_done, tx_done, ~buf_full, fe, 2'b00, dbl, 1'b0};
  wire [7:0] rd_b = {3'b000, rx_en, tx_en, fmt.size[2], rx_data[8], tx9};
  wire [7:0] rd_c = {fmt.xck_master, fmt.sync, fmt.parity, fmt.stop2,
      fmt.size[1:0], fmt.pol};
  wire [7:0] rd_byte = hit_a ? rd_a : hit_b ? rd_b : hit_c ? rd_c :
      hit_lo ? baud[7:0] : hit_hi ? {4'h0, baud[11:8]} :
      hit_d ? rx_data[7:0] : 8'h00;

  // One wait state, then a registered answer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready <= acc & ~apb_rsp.pready;
      apb_rsp.pslverr <= acc & ~apb_rsp.pready & ~mapped;
      apb_rsp.prdata <= (acc & ~apb_rsp.pready & ~apb_req.pwrite) ?
          {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ==========================================
  // Register writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dbl <= 1'b0;
      tx_en <= 1'b0;
      rx_en <= 1'b0;
      tx9 <= 1'b0;
      fmt <= '{sync: 1'b0, xck_master: 1'b0, pol: 1'b0, parity: 2'b00,
          stop2: 1'b0, size: RST_SIZE};
      baud <= RST_BAUD;
    end else if (wr_fire) begin
      if (hit_a) begin
        dbl <= wd[A_DOUBLE];
      end
      if (hit_b) begin
        rx_en <= wd[B_RX_EN];
        tx_en <= wd[B_TX_EN];
        fmt.size[2] <= wd[B_SIZE_HI]; // R7
        tx9 <= wd[B_TX_NINTH];
      end
      if (hit_c) begin
        fmt.xck_master <= wd[C_XCK_MASTER];
        fmt.sync <= wd[C_SYNC];
        fmt.parity <= wd[C_PAR_HI:C_PAR_LO]; // R8
        fmt.stop2 <= wd[C_STOP]; // R9
        fmt.size[1:0] <= wd[C_SIZE_HI:C_SIZE_LO]; // R7
        fmt.pol <= wd[C_POL];
      end
      if (hit_lo) begin
        baud[7:0] <= wd;
      end
      if (hit_hi) begin
        baud[11:8] <= wd[3:0];
      end
    end
  end

  // ==========================================
  // Rate generation
  logic baud_tick;
  // Low byte write reloads with the byte being written
  wire [11:0] div_now = lo_wr ? {baud[11:8], wd} : baud;

  uft_baud_gen u_baud (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .divisor(div_now),
    .reload(lo_wr), // R23
    .tick(baud_tick)
  );

  // Transfer clock input, synchronised then edge detected
  logic xs1;
  logic xs2;
  logic xs3;
  logic ph;
  logic [3:0] div_cnt;
  wire master = fmt.sync & fmt.xck_master;
  wire slave = fmt.sync & ~fmt.xck_master;
  wire x_rise = xs2 & ~xs3;
  wire x_fall = ~xs2 & xs3;
  wire [3:0] div_top = dbl ? DIV_DOUBLE : DIV_NORMAL;
  wire [3:0] os_mid = dbl ? MID_DOUBLE : MID_NORMAL;
  wire async_tick = ~fmt.sync & baud_tick & (div_cnt == div_top); // R24
  wire chg_edge = fmt.pol ? x_fall : x_rise; // R25
  wire smp_edge = fmt.pol ? x_rise : x_fall;
  wire tx_tick = async_tick | (master & baud_tick & ~ph) | (slave & chg_edge); // R16 R19
  wire sync_samp = (master & baud_tick & ph) | (slave & smp_edge);
  wire next_ph = master ? (ph ^ baud_tick) : 1'b0; // R24

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xs1 <= 1'b0;
      xs2 <= 1'b0;
      xs3 <= 1'b0;
      ph <= 1'b0;
      div_cnt <= 4'h0;
      xck_o <= 1'b0;
      xck_oe <= 1'b0;
    end else begin
      xs1 <= xck_i;
      xs2 <= xs1;
      xs3 <= xs2;
      ph <= next_ph;
      if (fmt.sync) begin
        div_cnt <= 4'h0;
      end else if (baud_tick) begin
        div_cnt <= (div_cnt == div_top) ? 4'h0 : div_cnt + 4'h1; // R24
      end
      xck_o <= next_ph ^ fmt.pol; // R25
      xck_oe <= master; // R16
    end
  end

  // ==========================================
  // Transmit buffer and shifter
  logic sh_txd;
  logic sh_busy;
  logic load_ack;
  logic frame_done;
  wire own = tx_en | sh_busy | buf_full;
  wire load_req = buf_full & (tx_en | sh_busy);

  uft_tx_shift u_shift (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bit_tick(tx_tick),
    .fmt(fmt), // R5
    .load_req(load_req),
    .load_data(buf_data),
    .load_ack(load_ack),
    .frame_done(frame_done),
    .txd(sh_txd),
    .busy(sh_busy)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buf_data <= 9'h000;
      buf_full <= 1'b0;
      tx_done <= 1'b0;
      txd_o <= 1'b1;
      txd_oe <= 1'b0;
    end else begin
      if (data_wr) begin
        buf_data <= {tx9, wd}; // R17
      end
      buf_full <= data_wr | (buf_full & ~load_ack); // R17 R26
      // Set wins over the write-one clear
      tx_done <= (frame_done & ~buf_full) |
          (tx_done & ~(wr_fire & hit_a & wd[A_TX_DONE]));
      txd_o <= own ? sh_txd : port_txd; // R15
      txd_oe <= own | port_txd_oe; // R15
    end
  end

  // ==========================================
  // Receiver, sharing the transmit format
  uft_rx_state_t rx_state;
  logic [3:0] rx_os;
  logic [3:0] rx_idx;
  logic [8:0] rx_sr;
  wire [3:0] nbits = data_bits(fmt.size); // R5
  wire [3:0] stop_idx = nbits + 4'h1 + {3'b000, fmt.parity[1]};
  wire rx_busy = (rx_state == RX_BUSY);
  wire start_async = rx_en & ~fmt.sync & baud_tick & ~rx_busy & ~rxd;
  wire start_sync = rx_en & sync_samp & ~rx_busy & ~rxd;
  wire rx_samp = rx_busy &
      (fmt.sync ? sync_samp : (baud_tick & (rx_os == os_mid)));
  wire rx_stop = rx_samp & (rx_idx == stop_idx); // R9
  wire rx_false = rx_samp & (rx_idx == 4'h0) & rxd;
  wire rx_data_bit = rx_samp & (rx_idx != 4'h0) & (rx_idx <= nbits);
  wire [3:0] rx_shift = BITS_MAX - nbits;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= RX_IDLE;
      rx_os <= 4'h0;
      rx_idx <= 4'h0;
      rx_sr <= 9'h000;
    end else begin
      unique case (rx_state)
        RX_IDLE: begin
          rx_os <= 4'h0;
          rx_idx <= start_sync ? 4'h1 : 4'h0;
          if (start_async | start_sync) begin
            rx_state <= RX_BUSY;
          end
        end
        RX_BUSY: begin
          if (baud_tick & ~fmt.sync) begin
            rx_os <= (rx_os == div_top) ? 4'h0 : rx_os + 4'h1;
          end
          if (rx_samp) begin
            rx_idx <= rx_idx + 4'h1;
          end
          if (rx_data_bit) begin
            rx_sr <= {rxd, rx_sr[8:1]};
          end
          if (rx_stop | rx_false) begin
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_data <= 9'h000;
      rx_done <= 1'b0;
      fe <= 1'b0;
    end else begin
      if (rx_stop) begin
        rx_data <= rx_sr >> rx_shift;
        fe <= ~rxd; // R10
      end
      rx_done <= rx_stop | (rx_done & ~data_rd);
    end
  end

  // ==========================================
  // Checks
  AST_PIN_OWN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tx_en |=> txd_oe) // R15
    else $error("serial pin not taken over while enabled");
  AST_PIN_FOLLOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
      own |=> txd_o == $past(sh_txd)) // R15
    else $error("serial pin does not follow the shifter");
  AST_WRITE_LOADS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      data_wr |=> buf_full && buf_data == {$past(tx9), $past(wd)}) // R17
    else $error("data write did not fill the buffer");
  AST_BUF_EMPTY: assert property (@(posedge clk_sys) disable iff (!rst_n)
      load_ack && !data_wr |=> !buf_full && rd_a[A_BUF_EMPTY]) // R26
    else $error("buffer empty flag not set after move");
  AST_FRAME_ERR: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_stop |=> fe == !$past(rxd) && rx_done) // R10
    else $error("frame error not tied to first stop bit");
  AST_SYNC_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      master && tx_tick && $stable(fmt) |=> xck_o == !fmt.pol) // R25
    else $error("data change on wrong transfer clock edge");
  AST_DIV_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
      async_tick |=> div_cnt == 4'h0) // R24
    else $error("bit divider did not wrap at its ratio");
  AST_TX_DONE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      frame_done && !buf_full |=> tx_done ##1 tx_done || $past(wr_fire)) // R4
    else $error("done flag not set after last frame");

  COV_FRAME: cover property (@(posedge clk_sys) disable iff (!rst_n)
      frame_done);
  COV_BACK_TO_BACK: cover property (@(posedge clk_sys) disable iff (!rst_n)
      load_ack && sh_busy);
  COV_RX: cover property (@(posedge clk_sys) disable iff (!rst_n)
      rx_stop && fmt.sync);
endmodule

// ### uft_peer.sv
`timescale 1ns/1ps
module uft_peer (
  // Clock
  input wire logic clk_sys,
  // Serial line and bit clock
  input wire logic line,
  input wire logic xck,
  // Frame setting
  input wire logic sync,
  input wire logic pol,
  input wire logic [15:0] bit_clks,
  input wire logic [15:0] n_bits,
  // Captured frame
  output logic [12:0] frame,
  output int n_frames
);
  // ==========================================
  // Sampling point: bit centre or sampling edge
  task automatic next_samp(input logic first);
    logic p;
    if (sync) begin
      p = xck;
      @(posedge clk_sys);
      while (!((xck != p) && (xck == pol))) begin
        p = xck;
        @(posedge clk_sys);
      end
    end else begin
      repeat (first ? bit_clks / 2 : bit_clks) @(posedge clk_sys);
    end
  endtask

  // ==========================================
  // Frame capture, back to back frames allowed
  initial begin
    frame = '1;
    n_frames = 0;
    forever begin
      do begin
        if (sync) next_samp(1'b0);
        else @(posedge clk_sys);
      end while (line !== 1'b0);
      if (!sync) next_samp(1'b1);
      frame = '1;
      frame[0] = line;
      for (int i = 1; i < n_bits; i++) begin
        next_samp(1'b0);
        frame[i] = line;
      end
      n_frames++;
    end
  end
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  import uft_pkg::*;
  // ==========================================
  // Signals
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  uft_apb_req_t apb_req = '0;
  uft_apb_rsp_t apb_rsp;
  logic port_txd = 1'b1;
  logic port_txd_oe = 1'b0;
  logic txd_o, txd_oe, xck_o, xck_oe, line, err;
  logic sync = 1'b0;
  logic pol = 1'b0;
  logic xck_ext = 1'b0;
  logic slv = 1'b0;
  logic [15:0] bit_clks = 16'h0010;
  logic [15:0] n_bits = 16'h000A;
  logic [12:0] frame;
  logic [31:0] rd;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
  logic [1:0] pars [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  int n_frames, cyc, c1;
  int n_fail = 0;
  int checks = 0;

  // Pull-up on the serial pin
  assign line = txd_oe ? txd_o : 1'b1;

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) cyc <= cyc + 1;

  // External transfer clock for slave mode, 16 clocks a period
  always begin
    repeat (8) @(posedge clk_sys);
    xck_ext <= ~xck_ext;
  end

  uft_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .port_txd(port_txd), .port_txd_oe(port_txd_oe), .txd_o(txd_o), .txd_oe(txd_oe),
    .rxd(line), .xck_i(xck_ext), .xck_o(xck_o), .xck_oe(xck_oe));

  uft_peer peer_u (.clk_sys(clk_sys), .line(line), .xck(xck_oe ? xck_o : xck_ext),
    .sync(sync), .pol(pol),
    .bit_clks(bit_clks), .n_bits(n_bits), .frame(frame), .n_frames(n_frames));

  // ==========================================
  // Helpers
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (apb_rsp.pready !== 1'b1) n_fail++;
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wait_empty;
    int k;
    k = 0;
    do begin
      apb(1'b0, ADDR_CTRL_A, 32'h0000_0000);
      k++;
    end while (rd[A_BUF_EMPTY] !== 1'b1 && k < 100);
    if (rd[A_BUF_EMPTY] !== 1'b1) n_fail++;
  endtask

  task automatic wait_n(input int target);
    int k;
    k = 0;
    while (n_frames < target && k < 4000) begin
      @(posedge clk_sys);
      k++;
    end
    chk("frame arrived", n_frames >= target, 1'b1);
  endtask

  function automatic logic [12:0] exp_frame(input logic [8:0] d, input logic [2:0] code,
      input logic [1:0] par, input logic stop2, output int len);
    int n;
    logic [12:0] f;
    n = (code == 3'h7) ? 9 : (code[2] ? 8 : 5 + code[1:0]);
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) f[1 + i] = d[i];
    if (par[1]) f[1 + n] = ^(d & ((9'h001 << n) - 9'h001)) ^ par[0];
    len = 2 + n + par[1] + stop2;
    return f;
  endfunction

  task automatic send(input logic [8:0] d, input logic [2:0] code, input logic [1:0] par,
      input logic stop2, input logic dbl, input logic [7:0] div, input logic sy, input logic pl);
    int len;
    int n;
    int t;
    logic [12:0] e;
    e = exp_frame(d, code, par, stop2, len);
    n = len - 2 - par[1] - stop2;
    n_bits = 16'(len);
    bit_clks = 16'((div + 1) * (sy ? 2 : (dbl ? 8 : 16)));
    sync = sy;
    pol = pl;
    apb(1'b1, ADDR_BAUD_HI, 32'h0000_0000);
    apb(1'b1, ADDR_BAUD_LO, {24'h00_0000, div});
    apb(1'b1, ADDR_CTRL_A, {24'h00_0000, 2'b01, 4'h0, dbl, 1'b0});
    apb(1'b1, ADDR_CTRL_C, {24'h00_0000, sy & ~slv, sy, par, stop2, code[1:0], pl});
    apb(1'b1, ADDR_CTRL_B, {27'h000_0000, 2'b11, code[2], 1'b0, d[8]});
    wait_empty;
    t = n_frames + 1;
    apb(1'b1, ADDR_DATA, {23'h00_0000, d});
    wait_n(t);
    chk("frame", frame, e);
    chk("pin owned", txd_oe, 1'b1);
    chk("clock pin owned", xck_oe, sy & ~slv);
    repeat (2 * bit_clks) @(posedge clk_sys);
    apb(1'b0, ADDR_CTRL_A, 32'h0000_0000);
    chk("tx done", rd[A_TX_DONE], 1'b1);
    chk("buffer empty", rd[A_BUF_EMPTY], 1'b1);
    chk("frame error", rd[A_FRAME_ERR], 1'b0);
    apb(1'b0, ADDR_DATA, 32'h0000_0000);
    chk("rx data", rd[7:0], n >= 8 ? d[7:0] : d[7:0] & 8'((9'h001 << n) - 1));
  endtask

  // ==========================================
  // Tests
  initial begin
    logic [12:0] e;
    int len;
    void'($urandom(32'haeecb387));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_CTRL_A, 32'h0000_0000);
    chk("ctrl_a reset", rd, 32'h0000_0020);
    apb(1'b0, ADDR_CTRL_B, 32'h0000_0000);
    chk("ctrl_b reset", rd, 32'h0000_0000);
    apb(1'b0, ADDR_CTRL_C, 32'h0000_0000);
    chk("ctrl_c reset", rd, 32'h0000_0006);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0000_0000);
    port_txd <= 1'b0;
    port_txd_oe <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("port pin", line, 1'b0);
    port_txd <= 1'b1;
    port_txd_oe <= 1'b0;
    // Let the peer finish the frame it took from the low port level
    repeat (200) @(posedge clk_sys);
    chk("pin released", txd_oe, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      send(9'($urandom), codes[i], pars[i % 4], i[0], 1'b0, 8'h00, 1'b0, 1'b0);
    end
    $display("test formats done");
    for (int i = 0; i < 10; i++) begin
      send(9'($urandom), codes[$urandom_range(5)], 2'($urandom), 1'($urandom), 1'($urandom),
        8'($urandom_range(2)), 1'b0, 1'b0);
    end
    $display("test random done");
    for (int i = 0; i < 2; i++) begin
      send(9'($urandom), codes[$urandom_range(5)], 2'($urandom), 1'($urandom), 1'b0,
        8'h03, 1'b1, i[0]);
    end
    slv = 1'b1;
    send(9'($urandom), 3'h7, 2'h3, 1'b1, 1'b0, 8'h03, 1'b1, 1'b0);
    slv = 1'b0;
    $display("test sync done");
    send(9'h0F0, 3'h3, 2'h0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
    len = n_frames;
    apb(1'b1, ADDR_DATA, 32'h0000_00A5);
    wait_empty;
    apb(1'b1, ADDR_DATA, 32'h0000_003C);
    apb(1'b0, ADDR_CTRL_A, 32'h0000_0000);
    chk("buffer full", rd[A_BUF_EMPTY], 1'b0);
    wait_n(len + 1);
    c1 = cyc;
    chk("first of pair", frame, exp_frame(9'h0A5, 3'h3, 2'h0, 1'b0, len));
    wait_n(n_frames + 1);
    chk("second of pair", frame, exp_frame(9'h03C, 3'h3, 2'h0, 1'b0, len));
    chk("no gap", (cyc - c1 >= 159) && (cyc - c1 <= 161), 1'b1);
    repeat (40) @(posedge clk_sys);
    chk("idle high", line, 1'b1);
    $display("test back to back done");
    give_verdict;
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    n_fail++;
    $display("watchdog expired");
    give_verdict;
  end
endmodule
